//--- logic/cip_ctrl_pkg.sv
/*
 * Shared constants for the component input control and monitor registers:
 * subaddresses, field positions, reset values and widths.
 * Assumes a control-bus slave elsewhere turns bus traffic into subaddress
 * read and write strobes on the processing clock.
 */
package cip_ctrl_pkg;

    // ------------------------------------------------------------------
    // Subaddresses
    // ------------------------------------------------------------------
    localparam int          ADDR_W      = 8;
    localparam int          DATA_W      = 16;
    localparam logic [7:0]  ADDR_CTRL   = 8'h96;
    localparam logic [7:0]  ADDR_MON    = 8'h97;
    localparam logic [7:0]  ADDR_VER    = 8'h9F;

    // ------------------------------------------------------------------
    // Control register layout
    // ------------------------------------------------------------------
    localparam int          CTRL_W      = 8;
    localparam int          BIT_RANGE   = 1;
    localparam int          BIT_PORT    = 2;
    localparam int          BIT_CLAMP   = 5;
    localparam int          BIT_BYPASS  = 6;
    localparam int          BIT_YUV     = 7;
    localparam logic [7:0]  CTRL_RESET  = 8'h40;
    localparam logic [7:0]  CTRL_WMASK  = 8'hE6;

    // ------------------------------------------------------------------
    // Monitor register layout
    // ------------------------------------------------------------------
    localparam int          MON_HIGH    = 0;
    localparam int          MON_FALL    = 1;
    localparam int          MON_RISE    = 2;
    localparam int          MON_LIVE    = 3;
    localparam int          MON_CLIP    = 4;

    // ------------------------------------------------------------------
    // Fast-blank clamp and version layout
    // ------------------------------------------------------------------
    localparam int          BLANK_W     = 7;
    localparam int          OFFS_W      = 6;
    localparam logic [6:0]  CLAMP_BASE  = 7'h1F;
    localparam int          VER_REV_LSB = 0;
    localparam int          VER_VAR_LSB = 8;
    localparam int          VER_FAM_LSB = 12;
    localparam logic [15:0] ZERO_WORD   = 16'h0000;

endpackage

//--- logic/blank_monitor.sv
/*
 * Sticky fast-blank level/edge flags and input clip flag.
 * Assumes fast_blank_input_in and clip_detect_in are synchronous to mclk_in
 * and clear_in is a one-cycle strobe for a read of the monitor register.
 */
module blank_monitor (
    // Clock and reset
    input  wire logic mclk_in,
    input  wire logic rstn_in,
    // Watched inputs
    input  wire logic fast_blank_input_in,
    input  wire logic clip_detect_in,
    input  wire logic clear_in,
    // Flags
    output logic      blank_level_high_flag_out,
    output logic      blank_falling_edge_flag_out,
    output logic      blank_rising_edge_flag_out,
    output logic      input_clip_flag_out
);

    logic prev_q;
    logic rise;
    logic fall;

    // ------------------------------------------------------------------
    // Edge detection
    // ------------------------------------------------------------------
    // Previous level resets low, so a high level at release counts as a rise
    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= fast_blank_input_in;
        end
    end

    assign rise = fast_blank_input_in & ~prev_q;
    assign fall = ~fast_blank_input_in & prev_q;

    // ------------------------------------------------------------------
    // Sticky flags, set wins over read clear
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            blank_level_high_flag_out <= 1'b0;
        end else if (fast_blank_input_in) begin
            blank_level_high_flag_out <= 1'b1;
        end else if (clear_in) begin
            blank_level_high_flag_out <= 1'b0;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            blank_falling_edge_flag_out <= 1'b0;
        end else if (fall) begin
            blank_falling_edge_flag_out <= 1'b1;
        end else if (clear_in) begin
            blank_falling_edge_flag_out <= 1'b0;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            blank_rising_edge_flag_out <= 1'b0;
        end else if (rise) begin
            blank_rising_edge_flag_out <= 1'b1;
        end else if (clear_in) begin
            blank_rising_edge_flag_out <= 1'b0;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            input_clip_flag_out <= 1'b0;
        end else if (clip_detect_in) begin
            input_clip_flag_out <= 1'b1;
        end else if (clear_in) begin
            input_clip_flag_out <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rstn_in);

    a_high_flag_set: assert property (fast_blank_input_in |=> blank_level_high_flag_out)
        else $error("level-high flag not set by high input");
    a_high_flag_clear: assert property ($fell(blank_level_high_flag_out) |->
        ($past(clear_in) && !$past(fast_blank_input_in)))
        else $error("level-high flag cleared without read and low input");
    a_fall_flag_set: assert property (prev_q && !fast_blank_input_in
        ##1 clear_in |-> blank_falling_edge_flag_out)
        else $error("falling-edge flag missing");
    a_rise_flag_set: assert property ((!prev_q && fast_blank_input_in && clear_in)
        |=> blank_rising_edge_flag_out)
        else $error("rising edge lost during read clear");
    a_clip_flag_life: assert property (clear_in && !clip_detect_in
        |=> !input_clip_flag_out)
        else $error("clip flag survived a read");

endmodule

//--- logic/component_input_control_monitor.sv
/*
 * Component input control, fast-blank/clip monitor and hardware version
 * registers, reached by subaddress read and write strobes.
 * Assumes a control-bus slave supplies one-cycle strobes on mclk_in and
 * that all video-side inputs are synchronous to mclk_in.
 */
// Operation
// - Extended range bit 0 selects the normal converter range, 1 the +3dB range.
// - Port select bit 0 routes component port 1 into the path, 1 routes port 2.
// - With blank clamp set the fast-blank value becomes 31 minus the offset field.
// - Decimation bypass set skips the 4:4:4 to 4:2:2 filter and resets to 1.
// - Colour space bit 0 treats the input as RGB, 1 as YUV.
// - Level-high flag sets on a high input and clears only on read with input low.
// - Falling-edge flag is sticky and cleared by a monitor read.
// - Rising-edge flag is sticky and cleared by a monitor read.
// - The live-level bit returns the fast-blank level at the moment of the read.
// - Clip flag is sticky on input clipping and cleared by a monitor read.
// - A read-only 16-bit version word holds the revision index in its low byte.
// - The version word carries a 2-bit variant code and a 4-bit family code.
// - Reset loads every writable control field with its default.
module component_input_control_monitor #(
    parameter logic [7:0] REVISION_INDEX = 8'h01, // arbitrary value
    parameter logic [1:0] VARIANT_CODE   = 2'h1,  // arbitrary value
    parameter logic [3:0] FAMILY_CODE    = 4'h5,  // arbitrary value
    parameter int         PIX_W          = 24
) (
    // Clock and reset
    input  wire logic                           mclk_in,
    input  wire logic                           rstn_in,
    // Register access
    input  wire logic [cip_ctrl_pkg::ADDR_W-1:0] reg_addr_in,
    input  wire logic                           reg_wr_in,
    input  wire logic                           reg_rd_in,
    input  wire logic [cip_ctrl_pkg::DATA_W-1:0] reg_wdata_in,
    output logic      [cip_ctrl_pkg::DATA_W-1:0] reg_rdata_out,
    output logic                                reg_rvalid_out,
    // Video side inputs
    input  wire logic                           fast_blank_input_in,
    input  wire logic                           clip_detect_in,
    input  wire logic [cip_ctrl_pkg::BLANK_W-1:0] fast_blank_value_in,
    input  wire logic [cip_ctrl_pkg::OFFS_W-1:0] blank_offset_correction_in,
    input  wire logic [PIX_W-1:0]               port1_data_in,
    input  wire logic [PIX_W-1:0]               port2_data_in,
    // Control outputs
    output logic                                extended_adc_range_out,
    output logic                                component_port_select_out,
    output logic                                blank_clamp_enable_out,
    output logic                                chroma_decimation_bypass_out,
    output logic                                yuv_select_out,
    // Processed video side outputs
    output logic      [cip_ctrl_pkg::BLANK_W-1:0] blank_value_out,
    output logic      [PIX_W-1:0]               component_data_out
);

    logic [cip_ctrl_pkg::CTRL_W-1:0] component_input_control_q;
    logic [cip_ctrl_pkg::DATA_W-1:0] hardware_version;
    logic [cip_ctrl_pkg::DATA_W-1:0] rdata_d;
    logic                            mon_read;
    logic                            high_flag;
    logic                            fall_flag;
    logic                            rise_flag;
    logic                            clip_flag;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
        hit = (addr == target);
    endfunction

    // ------------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------------
    // Reserved bits are never stored, so they read back as zero
    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            component_input_control_q <= cip_ctrl_pkg::CTRL_RESET;
        end else if (reg_wr_in && hit(reg_addr_in, cip_ctrl_pkg::ADDR_CTRL)) begin
            component_input_control_q <= reg_wdata_in[cip_ctrl_pkg::CTRL_W-1:0]
                                         & cip_ctrl_pkg::CTRL_WMASK;
        end
    end

    assign extended_adc_range_out       = component_input_control_q[cip_ctrl_pkg::BIT_RANGE];
    assign component_port_select_out    = component_input_control_q[cip_ctrl_pkg::BIT_PORT];
    assign blank_clamp_enable_out       = component_input_control_q[cip_ctrl_pkg::BIT_CLAMP];
    assign chroma_decimation_bypass_out = component_input_control_q[cip_ctrl_pkg::BIT_BYPASS];
    assign yuv_select_out               = component_input_control_q[cip_ctrl_pkg::BIT_YUV];

    // ------------------------------------------------------------------
    // Video path steering
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            component_data_out <= '0;
        end else if (component_port_select_out) begin
            component_data_out <= port2_data_in;
        end else begin
            component_data_out <= port1_data_in;
        end
    end

    // Offset above 31 gives a negative two's-complement clamp value
    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            blank_value_out <= '0;
        end else if (blank_clamp_enable_out) begin
            blank_value_out <= cip_ctrl_pkg::CLAMP_BASE
                               - {1'b0, blank_offset_correction_in};
        end else begin
            blank_value_out <= fast_blank_value_in;
        end
    end

    // ------------------------------------------------------------------
    // Monitor flags
    // ------------------------------------------------------------------
    assign mon_read = reg_rd_in && hit(reg_addr_in, cip_ctrl_pkg::ADDR_MON);

    blank_monitor u_blank_monitor (
        .mclk_in                     (mclk_in),
        .rstn_in                     (rstn_in),
        .fast_blank_input_in         (fast_blank_input_in),
        .clip_detect_in              (clip_detect_in),
        .clear_in                    (mon_read),
        .blank_level_high_flag_out   (high_flag),
        .blank_falling_edge_flag_out (fall_flag),
        .blank_rising_edge_flag_out  (rise_flag),
        .input_clip_flag_out         (clip_flag)
    );

    // ------------------------------------------------------------------
    // Version word and read mux
    // ------------------------------------------------------------------
    always_comb begin
        hardware_version = cip_ctrl_pkg::ZERO_WORD;
        hardware_version[cip_ctrl_pkg::VER_REV_LSB +: 8] = REVISION_INDEX;
        hardware_version[cip_ctrl_pkg::VER_VAR_LSB +: 2] = VARIANT_CODE;
        hardware_version[cip_ctrl_pkg::VER_FAM_LSB +: 4] = FAMILY_CODE;
    end

    // Flags are reported as held before this read; a same-cycle event shows next read
    always_comb begin
        rdata_d = cip_ctrl_pkg::ZERO_WORD;
        case (reg_addr_in)
            cip_ctrl_pkg::ADDR_CTRL: begin
                rdata_d[cip_ctrl_pkg::CTRL_W-1:0] = component_input_control_q;
            end
            cip_ctrl_pkg::ADDR_MON: begin
                rdata_d[cip_ctrl_pkg::MON_HIGH] = high_flag;
                rdata_d[cip_ctrl_pkg::MON_FALL] = fall_flag;
                rdata_d[cip_ctrl_pkg::MON_RISE] = rise_flag;
                rdata_d[cip_ctrl_pkg::MON_LIVE] = fast_blank_input_in;
                rdata_d[cip_ctrl_pkg::MON_CLIP] = clip_flag;
            end
            cip_ctrl_pkg::ADDR_VER: begin
                rdata_d = hardware_version;
            end
            default: begin
                rdata_d = cip_ctrl_pkg::ZERO_WORD;
            end
        endcase
    end

    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            reg_rdata_out <= cip_ctrl_pkg::ZERO_WORD;
        end else if (reg_rd_in) begin
            reg_rdata_out <= rdata_d;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            reg_rvalid_out <= 1'b0;
        end else begin
            reg_rvalid_out <= reg_rd_in;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rstn_in);

    a_reset_defaults: assert property (disable iff (1'b0)
        !rstn_in |=> (chroma_decimation_bypass_out && !extended_adc_range_out
        && !blank_clamp_enable_out && !yuv_select_out && !component_port_select_out))
        else $error("control defaults not loaded at reset");
    a_ctrl_write: assert property (reg_wr_in && hit(reg_addr_in, cip_ctrl_pkg::ADDR_CTRL)
        |=> (extended_adc_range_out == $past(reg_wdata_in[cip_ctrl_pkg::BIT_RANGE]))
        && (yuv_select_out == $past(reg_wdata_in[cip_ctrl_pkg::BIT_YUV])))
        else $error("control write not applied");
    a_port_route: assert property (##1 component_port_select_out ##1 1'b1
        |-> component_data_out == $past(port2_data_in))
        else $error("port 2 not routed");
    a_clamp_value: assert property (blank_clamp_enable_out
        |=> blank_value_out == 7'(cip_ctrl_pkg::CLAMP_BASE
            - {1'b0, $past(blank_offset_correction_in)}))
        else $error("clamp value wrong");
    a_live_level: assert property (mon_read
        |=> reg_rvalid_out && reg_rdata_out[cip_ctrl_pkg::MON_LIVE]
            == $past(fast_blank_input_in))
        else $error("live level not sampled at read");
    a_version_word: assert property (reg_rd_in && hit(reg_addr_in, cip_ctrl_pkg::ADDR_VER)
        |=> reg_rdata_out[7:0] == REVISION_INDEX
            && reg_rdata_out[15:12] == FAMILY_CODE)
        else $error("version word wrong");
    a_bypass_follow: assert property (reg_wr_in && hit(reg_addr_in, cip_ctrl_pkg::ADDR_CTRL)
        |=> chroma_decimation_bypass_out
            == $past(reg_wdata_in[cip_ctrl_pkg::BIT_BYPASS]))
        else $error("bypass bit not applied");

    c_mon_read_flag: cover property (high_flag && mon_read && !fast_blank_input_in);
    c_clamp_on:      cover property (blank_clamp_enable_out ##1 blank_value_out != '0);
    c_ver_read:      cover property (reg_rd_in && hit(reg_addr_in, cip_ctrl_pkg::ADDR_VER));

endmodule

//--- dv/host_bus_model.sv
/*
 * Host controller model for the subaddress register strobes.
 * Assumes the device takes a strobe on the rising edge of mclk_in and
 * answers a read one cycle later with a one-cycle valid pulse.
 */
module host_bus_model (
    // Clock
    input  wire logic        mclk_in,
    // Requests toward the device
    output logic [7:0]       reg_addr_out,
    output logic             reg_wr_out,
    output logic             reg_rd_out,
    output logic [15:0]      reg_wdata_out,
    // Read answer
    input  wire logic [15:0] reg_rdata_in,
    input  wire logic        reg_rvalid_in
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        reg_addr_out  = 8'h00;
        reg_wr_out    = 1'b0;
        reg_rd_out    = 1'b0;
        reg_wdata_out = 16'h0000;
    end

    // --------------------------------------------------------------
    // Bus cycles
    // --------------------------------------------------------------
    // Released lines show inverted values so a stale word never looks valid
    task automatic write_reg(input logic [7:0] addr, input logic [15:0] data);
        @(posedge mclk_in);
        reg_addr_out  <= addr;
        reg_wdata_out <= (addr == cip_ctrl_pkg::ADDR_CTRL) ?
                         (data & {8'h00, cip_ctrl_pkg::CTRL_WMASK}) : data;
        reg_wr_out    <= 1'b1;
        @(posedge mclk_in);
        reg_wr_out    <= 1'b0;
        reg_addr_out  <= ~addr;
        reg_wdata_out <= ~data;
    endtask

    task automatic read_reg(input logic [7:0] addr, output logic [15:0] data,
                            output logic valid);
        @(posedge mclk_in);
        reg_addr_out <= addr;
        reg_rd_out   <= 1'b1;
        @(posedge mclk_in);
        reg_rd_out   <= 1'b0;
        reg_addr_out <= ~addr;
        #1;
        data  = reg_rdata_in;
        valid = reg_rvalid_in;
    endtask
endmodule

//--- dv/component_input_control_monitor_bench.sv
/*
 * Self-checking bench for the component input control and monitor block.
 * Assumes the host model drives the register strobes and the bench drives
 * the video-side inputs at rising edges of mclk_in.
 */
module component_input_control_monitor_bench;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [7:0] REV = 8'h01; // arbitrary value
    localparam logic [1:0] VAR = 2'h1;  // arbitrary value
    localparam logic [3:0] FAM = 4'h5;  // arbitrary value

    logic        mclk_in = 1'b0;
    logic        rstn_in = 1'b0;
    logic [7:0]  reg_addr;
    logic        reg_wr;
    logic        reg_rd;
    logic [15:0] reg_wdata;
    logic [15:0] reg_rdata;
    logic        reg_rvalid;
    logic        blank_lvl = 1'b0;
    logic        clip_in = 1'b0;
    logic [6:0]  blank_norm = 7'h55;
    logic [5:0]  offs = 6'h00;
    logic [23:0] port1 = 24'hA5A5A5;
    logic [23:0] port2 = 24'h5A5A5A;
    logic        adc_range, psel, clamp, bypass, yuv;
    logic [6:0]  blank_value;
    logic [23:0] comp_data;
    int          failures = 0;
    int          checks_done = 0;
    logic [15:0] rd;
    logic        rv;

    always #10 mclk_in = ~mclk_in;

    component_input_control_monitor #(.REVISION_INDEX(REV), .VARIANT_CODE(VAR),
        .FAMILY_CODE(FAM), .PIX_W(24)) u_component_input_control_monitor (
        .mclk_in(mclk_in), .rstn_in(rstn_in), .reg_addr_in(reg_addr),
        .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_wdata_in(reg_wdata),
        .reg_rdata_out(reg_rdata), .reg_rvalid_out(reg_rvalid),
        .fast_blank_input_in(blank_lvl), .clip_detect_in(clip_in),
        .fast_blank_value_in(blank_norm), .blank_offset_correction_in(offs),
        .port1_data_in(port1), .port2_data_in(port2),
        .extended_adc_range_out(adc_range), .component_port_select_out(psel),
        .blank_clamp_enable_out(clamp), .chroma_decimation_bypass_out(bypass),
        .yuv_select_out(yuv), .blank_value_out(blank_value),
        .component_data_out(comp_data));

    host_bus_model u_host_bus_model (
        .mclk_in(mclk_in), .reg_addr_out(reg_addr), .reg_wr_out(reg_wr),
        .reg_rd_out(reg_rd), .reg_wdata_out(reg_wdata), .reg_rdata_in(reg_rdata),
        .reg_rvalid_in(reg_rvalid));

    // --------------------------------------------------------------
    // Shared checking
    // --------------------------------------------------------------
    task automatic check(input string what, input logic [23:0] seen,
                         input logic [23:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic read_check(input string what, input logic [7:0] addr,
                              input logic [15:0] exp);
        u_host_bus_model.read_reg(addr, rd, rv);
        check({what, " valid"}, {23'h0, rv}, 24'h000001);
        check(what, {8'h00, rd}, {8'h00, exp});
    endtask

    task automatic print_verdict();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // --------------------------------------------------------------
    // Scenarios
    // --------------------------------------------------------------
    task automatic test_control_reg();
        check("ctrl outs reset", {19'h0, yuv, bypass, clamp, psel, adc_range}, 24'h08);
        read_check("ctrl reset", cip_ctrl_pkg::ADDR_CTRL, 16'h0040);
        u_host_bus_model.write_reg(cip_ctrl_pkg::ADDR_CTRL, 16'h00E6);
        #1;
        check("ctrl outs set", {19'h0, yuv, bypass, clamp, psel, adc_range}, 24'h1F);
        read_check("ctrl set", cip_ctrl_pkg::ADDR_CTRL, 16'h00E6);
        u_host_bus_model.write_reg(cip_ctrl_pkg::ADDR_CTRL, 16'h0000);
        #1;
        check("ctrl outs clear", {19'h0, yuv, bypass, clamp, psel, adc_range}, 24'h00);
        // Mid-run reset must bring the defaults back over written values
        @(posedge mclk_in);
        rstn_in <= 1'b0;
        repeat (2) @(posedge mclk_in);
        rstn_in <= 1'b1;
        #1;
        check("ctrl outs rereset", {19'h0, yuv, bypass, clamp, psel, adc_range}, 24'h08);
    endtask

    task automatic test_video_path();
        logic [5:0] offs_tab [4];
        offs_tab = '{6'h00, 6'h1F, 6'h28, 6'h3F};
        u_host_bus_model.write_reg(cip_ctrl_pkg::ADDR_CTRL, 16'h0024);
        foreach (offs_tab[i]) begin
            @(posedge mclk_in);
            offs <= offs_tab[i];
            repeat (2) @(posedge mclk_in);
            #1;
            check("clamped blank", {17'h0, blank_value},
                  {17'h0, 7'(cip_ctrl_pkg::CLAMP_BASE - {1'b0, offs_tab[i]})});
        end
        check("port 2 data", comp_data, port2);
        u_host_bus_model.write_reg(cip_ctrl_pkg::ADDR_CTRL, 16'h0000);
        repeat (2) @(posedge mclk_in);
        #1;
        check("plain blank", {17'h0, blank_value}, {17'h0, blank_norm});
        check("port 1 data", comp_data, port1);
    endtask

    task automatic test_blank_monitor();
        read_check("mon idle", cip_ctrl_pkg::ADDR_MON, 16'h0000);
        @(posedge mclk_in);
        blank_lvl <= 1'b1;
        repeat (3) @(posedge mclk_in);
        read_check("mon rise", cip_ctrl_pkg::ADDR_MON, 16'h000D);
        @(posedge mclk_in);
        blank_lvl <= 1'b0;
        repeat (3) @(posedge mclk_in);
        read_check("mon fall", cip_ctrl_pkg::ADDR_MON, 16'h0003);
        read_check("mon cleared", cip_ctrl_pkg::ADDR_MON, 16'h0000);
        @(posedge mclk_in);
        blank_lvl <= 1'b1;
        repeat (2) @(posedge mclk_in);
        read_check("mon live", cip_ctrl_pkg::ADDR_MON, 16'h000D);
        read_check("mon held", cip_ctrl_pkg::ADDR_MON, 16'h0009);
        @(posedge mclk_in);
        blank_lvl <= 1'b0;
        repeat (2) @(posedge mclk_in);
        read_check("mon fall 2", cip_ctrl_pkg::ADDR_MON, 16'h0003);
        read_check("mon empty", cip_ctrl_pkg::ADDR_MON, 16'h0000);
    endtask

    task automatic test_clip_flag();
        @(posedge mclk_in);
        clip_in <= 1'b1;
        @(posedge mclk_in);
        clip_in <= 1'b0;
        repeat (2) @(posedge mclk_in);
        read_check("clip set", cip_ctrl_pkg::ADDR_MON, 16'h0010);
        read_check("clip cleared", cip_ctrl_pkg::ADDR_MON, 16'h0000);
        fork
            u_host_bus_model.read_reg(cip_ctrl_pkg::ADDR_MON, rd, rv);
            begin
                @(posedge mclk_in);
                clip_in <= 1'b1;
                @(posedge mclk_in);
                clip_in <= 1'b0;
            end
        join
        check("clip before", {8'h00, rd}, 24'h000000);
        read_check("clip kept", cip_ctrl_pkg::ADDR_MON, 16'h0010);
    endtask

    task automatic test_version();
        read_check("version", cip_ctrl_pkg::ADDR_VER, {FAM, 2'b00, VAR, REV});
        u_host_bus_model.write_reg(cip_ctrl_pkg::ADDR_VER, 16'h0000);
        u_host_bus_model.write_reg(cip_ctrl_pkg::ADDR_MON, 16'h001F);
        read_check("version fixed", cip_ctrl_pkg::ADDR_VER, {FAM, 2'b00, VAR, REV});
        read_check("mon unwritten", cip_ctrl_pkg::ADDR_MON, 16'h0000);
        read_check("unmapped", 8'h50, 16'h0000);
    endtask

    // --------------------------------------------------------------
    // Main sequence and watchdog
    // --------------------------------------------------------------
    initial begin
        repeat (12) @(posedge mclk_in);
        rstn_in <= 1'b1;
        test_control_reg();
        test_video_path();
        test_blank_monitor();
        test_clip_flag();
        test_version();
        print_verdict();
    end

    // Whole run needs about a hundred cycles
    initial begin
        repeat (5000) @(posedge mclk_in);
        failures++;
        print_verdict();
    end
endmodule
